// File: rtl/sp4_serial_port.v
// Our own choices: the address map and register access over Wishbone.
`timescale 1ns/1ps
`include "sp4_map.vh"
// Summary of operation
// (RULE1) Buffer writes transmit; reads return receive buffer
// (RULE2) Mode 0: eight bits LSB first, clock driven
// (RULE3) Mode 0 rate 1/12 or 1/4 by fast bit
// (RULE4) Mode 0 setup/low times 1/2 or 3/6 clocks
// (RULE5) Mode 0 transmit flag after last bit
// (RULE6) Mode 0 receive starts when enabled, flag clear
// (RULE7) Partner changes data on clock falling edge
// (RULE8) Mode 0 receive flag after last rise
// (RULE9) Mode 1 ten-bit frame, stop into ninth bit
// (RULE10) Mode 1 rate 1/16 or 1/32 of overflow
// (RULE11) Async bits start on divide-by-16 rollovers
// (RULE12) Transmit flag at 10th or 11th rollover
// (RULE13) Receiver samples 16x, falling edge resets counter
// (RULE14) Bit by majority of samples 8,9,10
// (RULE15) Non-zero start bit aborts frame
// (RULE16) Load only if flag clear and filter passes
// (RULE17) After stop middle, hunt falling edge again
// (RULE18) Mode 2 eleven bits with sent ninth bit
// (RULE19) Mode 2 rate 1/32 or 1/64 oscillator
// (RULE20) Mode 3 like mode 2, timer rate
// (RULE21) Framing error sticky until software clears
// (RULE22) Control bit 7 shows error or mode bit
// (RULE23) Mode bits decode to modes 0 to 3
module sp4_serial_port (
   // System
   input wire mclk,
   input wire reset_n,
   // Wishbone slave
   input wire wb_cyc_i,
   input wire wb_stb_i,
   input wire wb_we_i,
   input wire [3:0] wb_adr_i,
   input wire [3:0] wb_sel_i,
   input wire [31:0] wb_dat_i,
   output reg [31:0] wb_dat_o,
   output reg wb_ack_o,
   // Baud source
   input wire timerOverflow,
   // Serial pins
   input wire serialDataIn,
   output reg serialDataOut,
   output reg serialDataOe,
   output reg shiftClockOut
);

   //----------------------------------------------------------
   // Registers
   //----------------------------------------------------------
   reg [7:0] txBuf_q;
   reg [7:0] rxBuf_q;
   reg [7:0] ctrl_q;
   reg [7:0] pwr_q;
   reg frameErr_q;
   reg modeHigh_q;
   reg [1:0] rxSync_q;
   reg [1:0] ovSync_q;
   reg ovLast_q;

   wire [1:0] mode = {modeHigh_q, ctrl_q[`SP4_CTRL_SML]}; // [RULE23]
   wire sm2 = ctrl_q[`SP4_CTRL_SM2];
   wire rxIn = rxSync_q[1];
   wire busReq = wb_cyc_i & wb_stb_i & ~wb_ack_o;
   wire wrBuf = busReq & wb_we_i & wb_sel_i[0] &
      (wb_adr_i == `SP4_ADDR_BUF); // [RULE1]
   wire wrCtrl = busReq & wb_we_i & wb_sel_i[0] &
      (wb_adr_i == `SP4_ADDR_CTRL);
   wire wrPwr = busReq & wb_we_i & wb_sel_i[0] &
      (wb_adr_i == `SP4_ADDR_PWR);

   //----------------------------------------------------------
   // 16x tick generation
   //----------------------------------------------------------
   // Timer overflow arrives from outside; synchronised first
   reg [5:0] oscCnt_q;
   reg tick16;
   reg halfTog_q;
   wire ovEdge = ovSync_q[1] & ~ovLast_q;
   wire [5:0] oscDiv = pwr_q[`SP4_PWR_DBL] ? `SP4_OSC_DIV_FAST :
      `SP4_OSC_DIV_SLOW; // [RULE19]
   always @* begin
      if (mode == `SP4_MODE2) begin
         tick16 = (oscCnt_q == oscDiv - 6'h01); // [RULE19]
      end else if (pwr_q[`SP4_PWR_DBL]) begin
         tick16 = ovEdge; // [RULE10] [RULE20]
      end else begin
         tick16 = ovEdge & halfTog_q; // [RULE10]
      end
   end

   always @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         oscCnt_q <= 6'h00;
         halfTog_q <= 1'b0;
         rxSync_q <= 2'h3;
         ovSync_q <= 2'h0;
         ovLast_q <= 1'b0;
      end else begin
         rxSync_q <= {rxSync_q[0], serialDataIn};
         ovSync_q <= {ovSync_q[0], timerOverflow};
         ovLast_q <= ovSync_q[1];
         if (ovEdge) begin
            halfTog_q <= ~halfTog_q;
         end
         if (tick16 && mode == `SP4_MODE2) begin
            oscCnt_q <= 6'h00;
         end else begin
            oscCnt_q <= oscCnt_q + 6'h01;
         end
      end
   end

   //----------------------------------------------------------
   // Transmitter and mode 0 engine
   //----------------------------------------------------------
   localparam [3:0] TX_IDLE = 4'h1;
   localparam [3:0] TX_WAIT = 4'h2;
   localparam [3:0] TX_SEND = 4'h4;
   localparam [3:0] TX_SYNC = 4'h8;
   reg [3:0] txState_q;
   reg [3:0] txDiv_q;
   reg [3:0] txBits_q;
   reg [10:0] txShift_q;
   reg [3:0] m0Cnt_q;
   reg m0Low_q;
   reg m0Rx_q, m0Take_q;
   reg txFlagSet;
   reg rxFlagSet0;
   wire m0Fast = sm2; // [RULE3]
   wire [3:0] m0Setup = m0Fast ? `SP4_M0_SETUP_FAST : `SP4_M0_SETUP_SLOW;
   wire [3:0] m0LowT = m0Fast ? `SP4_M0_LOW_FAST : `SP4_M0_LOW_SLOW;
   wire [3:0] m0HighT = m0Fast ? `SP4_M0_HIGH_FAST : `SP4_M0_HIGH_SLOW;
   wire m0RxStart = (mode == `SP4_MODE0) & ctrl_q[`SP4_CTRL_REN] &
      ~ctrl_q[`SP4_CTRL_RI] & (txState_q == TX_IDLE) & ~wrBuf &
      ~m0Take_q & ~rxFlagSet0; // [RULE6]
   // Free-running tx divide-by-16, not aligned to the write
   wire txRoll = tick16 & (txDiv_q == 4'hf); // [RULE11]

   always @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         txState_q <= TX_IDLE;
         txDiv_q <= 4'h0;
         txBits_q <= 4'h0;
         txShift_q <= 11'h7ff;
         m0Cnt_q <= 4'h0;
         m0Low_q <= 1'b0;
         m0Rx_q <= 1'b0;
         m0Take_q <= 1'b0;
         serialDataOut <= 1'b1;
         serialDataOe <= 1'b1;
         shiftClockOut <= 1'b1;
         txFlagSet <= 1'b0;
         rxFlagSet0 <= 1'b0;
      end else begin
         txFlagSet <= 1'b0;
         m0Take_q <= 1'b0;
         rxFlagSet0 <= m0Take_q & (txBits_q == 4'h0); // [RULE8]
         if (m0Take_q) begin
            txShift_q <= {rxIn, txShift_q[10:1]};
         end
         if (tick16) begin
            txDiv_q <= txDiv_q + 4'h1;
         end
         case (txState_q)
            TX_IDLE: begin
               m0Low_q <= 1'b0;
               shiftClockOut <= 1'b1;
               if (mode == `SP4_MODE0) begin
                  serialDataOe <= ~ctrl_q[`SP4_CTRL_REN];
               end else begin
                  serialDataOe <= 1'b1;
                  serialDataOut <= 1'b1;
               end
               if (wrBuf && mode == `SP4_MODE0) begin
                  txShift_q <= {3'h7, wb_dat_i[7:0]}; // [RULE2]
                  txBits_q <= `SP4_BITS_M0;
                  m0Rx_q <= 1'b0;
                  m0Cnt_q <= 4'h0;
                  serialDataOe <= 1'b1;
                  txState_q <= TX_SYNC;
               end else if (wrBuf) begin
                  txShift_q <= (mode == `SP4_MODE1) ?
                     {2'h3, wb_dat_i[7:0], 1'b0} :
                     {1'b1, ctrl_q[`SP4_CTRL_TB8], wb_dat_i[7:0],
                      1'b0}; // [RULE9] [RULE18]
                  txBits_q <= (mode == `SP4_MODE1) ? `SP4_BITS_M1 :
                     `SP4_BITS_M2;
                  txState_q <= TX_WAIT;
               end else if (m0RxStart) begin
                  txBits_q <= `SP4_BITS_M0;
                  m0Rx_q <= 1'b1;
                  m0Cnt_q <= 4'h0;
                  serialDataOe <= 1'b0;
                  txState_q <= TX_SYNC;
               end
            end
            TX_WAIT: begin
               if (txRoll) begin
                  serialDataOut <= txShift_q[0]; // [RULE11]
                  txShift_q <= {1'b1, txShift_q[10:1]};
                  txBits_q <= txBits_q - 4'h1;
                  if (txBits_q == 4'h1) begin
                     txState_q <= TX_SEND;
                  end
               end
            end
            TX_SEND: begin
               // Flag one clock after the stop bit appears
               txFlagSet <= 1'b1; // [RULE12]
               txState_q <= TX_IDLE;
            end
            TX_SYNC: begin
               // Mode 0: high phase, setup, low phase per bit
               m0Cnt_q <= m0Cnt_q + 4'h1;
               if (!m0Low_q) begin
                  if (m0Cnt_q == m0HighT - 4'h1 && !m0Rx_q) begin
                     serialDataOut <= txShift_q[0]; // [RULE2]
                  end
                  if (m0Cnt_q == m0HighT + m0Setup - 4'h1) begin
                     shiftClockOut <= 1'b0; // [RULE4]
                     m0Low_q <= 1'b1;
                     m0Cnt_q <= 4'h0;
                  end
               end else if (m0Cnt_q == m0LowT - 4'h1) begin
                  shiftClockOut <= 1'b1; // [RULE4]
                  m0Low_q <= 1'b0;
                  m0Cnt_q <= 4'h0;
                  // Synchroniser delay: rise sample taken a clock later
                  m0Take_q <= m0Rx_q; // [RULE6] [RULE7]
                  if (!m0Rx_q) begin
                     txShift_q <= {1'b1, txShift_q[10:1]};
                  end
                  txBits_q <= txBits_q - 4'h1;
                  if (txBits_q == 4'h1) begin
                     txState_q <= TX_IDLE;
                     txFlagSet <= ~m0Rx_q; // [RULE5]
                  end
               end
            end
            default: begin
               txState_q <= TX_IDLE;
            end
         endcase
      end
   end

   //----------------------------------------------------------
   // Asynchronous receiver
   //----------------------------------------------------------
   localparam [2:0] RX_HUNT = 3'h1;
   localparam [2:0] RX_BITS = 3'h2;
   localparam [2:0] RX_DONE = 3'h4;
   reg [2:0] rxState_q;
   reg [3:0] rxDiv_q;
   reg [3:0] rxCnt_q;
   reg [9:0] rxShift_q;
   reg [2:0] votes_q;
   reg rxLast_q;
   reg rxFlagSet;
   reg rxLoad;
   reg feSet;
   wire vote = (votes_q[0] & votes_q[1]) | (votes_q[0] & votes_q[2]) |
      (votes_q[1] & votes_q[2]); // [RULE14]
   wire rxEnable = ctrl_q[`SP4_CTRL_REN] & (mode != `SP4_MODE0);
   wire [3:0] rxLen = (mode == `SP4_MODE1) ? `SP4_BITS_M1 : `SP4_BITS_M2;

   always @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         rxState_q <= RX_HUNT;
         rxDiv_q <= 4'h0;
         rxCnt_q <= 4'h0;
         rxShift_q <= 10'h000;
         votes_q <= 3'h7;
         rxLast_q <= 1'b1;
         rxFlagSet <= 1'b0;
         rxLoad <= 1'b0;
         feSet <= 1'b0;
      end else begin
         rxFlagSet <= 1'b0;
         rxLoad <= 1'b0;
         feSet <= 1'b0;
         if (tick16) begin
            rxLast_q <= rxIn;
            rxDiv_q <= rxDiv_q + 4'h1;
         end
         case (rxState_q)
            RX_HUNT: begin
               if (rxEnable && tick16 && rxLast_q && !rxIn) begin
                  rxDiv_q <= 4'h0; // [RULE13]
                  rxCnt_q <= 4'h0;
                  rxState_q <= RX_BITS;
               end
            end
            RX_BITS: begin
               if (tick16) begin
                  if (rxDiv_q == `SP4_VOTE_A) begin
                     votes_q[0] <= rxIn;
                  end
                  if (rxDiv_q == `SP4_VOTE_B) begin
                     votes_q[1] <= rxIn;
                  end
                  if (rxDiv_q == `SP4_VOTE_C) begin
                     votes_q[2] <= rxIn;
                  end
               end
               if (tick16 && rxDiv_q == `SP4_VOTE_C + 4'h1) begin
                  rxCnt_q <= rxCnt_q + 4'h1;
                  rxShift_q <= {vote, rxShift_q[9:1]};
                  if (rxCnt_q == 4'h0 && vote) begin
                     rxState_q <= RX_HUNT; // [RULE15]
                  end else if (rxCnt_q == rxLen - 4'h1) begin
                     rxState_q <= RX_DONE;
                  end
               end
               if (!rxEnable) begin
                  rxState_q <= RX_HUNT;
               end
            end
            RX_DONE: begin
               // Stop bit at rxShift_q[9]
               feSet <= ~rxShift_q[9]; // [RULE21]
               if (!ctrl_q[`SP4_CTRL_RI] &&
                   (!sm2 || rxShift_q[9])) begin // [RULE16]
                  rxLoad <= 1'b1;
                  rxFlagSet <= 1'b1;
               end
               rxState_q <= RX_HUNT; // [RULE17]
            end
            default: begin
               rxState_q <= RX_HUNT;
            end
         endcase
      end
   end

   // Data bits sit below stop (and ninth) bit in the shifter
   wire [7:0] rxData = (mode == `SP4_MODE1) ? rxShift_q[8:1] :
      rxShift_q[7:0];
   wire rxNinth = (mode == `SP4_MODE1) ? rxShift_q[9] : rxShift_q[8];

   //----------------------------------------------------------
   // Register file and bus
   //----------------------------------------------------------
   // Hardware set wins over a software clear in the same cycle
   wire [7:0] ctrlRead = {pwr_q[`SP4_PWR_FEV] ? frameErr_q : modeHigh_q,
      ctrl_q[6:0]}; // [RULE22]
   always @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         txBuf_q <= 8'h00;
         rxBuf_q <= 8'h00;
         ctrl_q <= 8'h00;
         pwr_q <= 8'h00;
         frameErr_q <= 1'b0;
         modeHigh_q <= 1'b0;
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h00000000;
      end else begin
         wb_ack_o <= busReq;
         if (wrBuf) begin
            txBuf_q <= wb_dat_i[7:0]; // [RULE1]
         end
         if (wrPwr) begin
            pwr_q <= wb_dat_i[7:0];
         end
         if (wrCtrl) begin
            ctrl_q <= {1'b0, wb_dat_i[6:0]};
            if (pwr_q[`SP4_PWR_FEV]) begin
               frameErr_q <= wb_dat_i[7] | feSet; // [RULE22]
            end else begin
               modeHigh_q <= wb_dat_i[7];
            end
         end
         if (feSet) begin
            frameErr_q <= 1'b1; // [RULE21]
         end
         if (txFlagSet) begin
            ctrl_q[`SP4_CTRL_TI] <= 1'b1;
         end
         if (rxFlagSet || rxFlagSet0) begin
            ctrl_q[`SP4_CTRL_RI] <= 1'b1;
         end
         if (rxLoad) begin
            rxBuf_q <= rxData;
            ctrl_q[`SP4_CTRL_RB8] <= rxNinth; // [RULE9] [RULE18]
         end
         if (rxFlagSet0) begin
            rxBuf_q <= txShift_q[10:3];
         end
         if (busReq && !wb_we_i) begin
            case (wb_adr_i)
               `SP4_ADDR_BUF: wb_dat_o <= {24'h000000, rxBuf_q}; // [RULE1]
               `SP4_ADDR_CTRL: wb_dat_o <= {24'h000000, ctrlRead};
               `SP4_ADDR_PWR: wb_dat_o <= {24'h000000, pwr_q};
               default: wb_dat_o <= 32'h00000000;
            endcase
         end
      end
   end

endmodule

// File: common/sp4_map.vh
`ifndef SP4_MAP_VH
`define SP4_MAP_VH
// Register word addresses (byte address = 4 x word)
`define SP4_ADDR_BUF 4'h0
`define SP4_ADDR_CTRL 4'h1
`define SP4_ADDR_PWR 4'h2
// Control register fields
`define SP4_CTRL_RI 0
`define SP4_CTRL_TI 1
`define SP4_CTRL_RB8 2
`define SP4_CTRL_TB8 3
`define SP4_CTRL_REN 4
`define SP4_CTRL_SM2 5
`define SP4_CTRL_SML 6
`define SP4_CTRL_SMH 7
// Power control fields
`define SP4_PWR_FEV 6
`define SP4_PWR_DBL 7
// Mode codes {high,low}
`define SP4_MODE0 2'h0
`define SP4_MODE1 2'h1
`define SP4_MODE2 2'h2
`define SP4_MODE3 2'h3
// Mode 0 timing in clocks
`define SP4_M0_SETUP_FAST 4'h1
`define SP4_M0_LOW_FAST 4'h2
`define SP4_M0_SETUP_SLOW 4'h3
`define SP4_M0_LOW_SLOW 4'h6
`define SP4_M0_HIGH_FAST 4'h1
`define SP4_M0_HIGH_SLOW 4'h3
// Oversample divisors (system clocks per 16x tick, mode 2)
`define SP4_OSC_DIV_FAST 6'h02
`define SP4_OSC_DIV_SLOW 6'h04
// Vote points in the 16-state counter
`define SP4_VOTE_A 4'h7
`define SP4_VOTE_B 4'h8
`define SP4_VOTE_C 4'h9
`define SP4_BITS_M1 4'ha
`define SP4_BITS_M2 4'hb
`define SP4_BITS_M0 4'h8
`endif

// File: verif/sp4_serial_port_properties.sv
`timescale 1ns/1ps
module sp4_serial_port_props (
   // System
   input wire mclk,
   input wire reset_n,
   // Bus
   input wire wb_cyc_i,
   input wire wb_stb_i,
   input wire wb_we_i,
   input wire [3:0] wb_adr_i,
   input wire [3:0] wb_sel_i,
   input wire [31:0] wb_dat_i,
   input wire [31:0] wb_dat_o,
   input wire wb_ack_o,
   // Line
   input wire timerOverflow,
   input wire serialDataIn,
   input wire serialDataOut,
   input wire serialDataOe,
   input wire shiftClockOut
);
   default clocking @(posedge mclk); endclocking
   default disable iff (!reset_n);
   // ------------------------------
   // Shift clock low phase sequences; bus handshake and shift clock checks
   // ------------------------------
   sequence sLowMin;
      !shiftClockOut [*2];
   endsequence
   sequence sBackHigh;
      ##[1:6] shiftClockOut;
   endsequence
   a_ack_one_late:
      assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
      else $error("ack missing after request");
   a_ack_single:
      assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack longer than one cycle");
   a_ack_has_req:
      assert property ($rose(wb_ack_o) |-> $past(wb_cyc_i && wb_stb_i))
      else $error("ack without request");
   a_rd_upper_zero:
      assert property (wb_ack_o && !wb_we_i |-> wb_dat_o[31:8] == 24'h0)
      else $error("read data upper bits set");
   a_rd_data_holds:
      assert property ($changed(wb_dat_o) |-> wb_ack_o && !wb_we_i)
      else $error("read data moved outside read");
   a_clk_low_min:
      assert property ($fell(shiftClockOut) |-> sLowMin)
      else $error("shift clock low too short");
   a_clk_low_max:
      assert property ($fell(shiftClockOut) |-> sBackHigh)
      else $error("shift clock low too long");
   a_data_setup:
      assert property ($fell(shiftClockOut) && serialDataOe
         |-> $stable(serialDataOut))
      else $error("data moved at shift clock fall");
   a_data_low_hold:
      assert property (!shiftClockOut && serialDataOe
         |=> shiftClockOut || $stable(serialDataOut))
      else $error("data moved while shift clock low");
endmodule

bind sp4_serial_port sp4_serial_port_props u_props (.mclk(mclk),
   .reset_n(reset_n), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
   .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
   .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
   .timerOverflow(timerOverflow), .serialDataIn(serialDataIn),
   .serialDataOut(serialDataOut), .serialDataOe(serialDataOe),
   .shiftClockOut(shiftClockOut));

// File: verif/sp4_line_model.sv
`timescale 1ns/1ps
module sp4_line_model (
   // Clocks
   input wire mclk,
   input wire shiftClk,
   // Line towards the port
   output reg line
);
   reg [7:0] m0Byte;
   reg m0Arm;
   initial begin
      line = 1'b1;
      m0Arm = 1'b0;
      m0Byte = 8'h00;
   end
   // Call just after a clock edge; pulled-up line idles high
   task automatic send(input logic [10:0] bits, input int n,
         input int bc);
      for (int i = 0; i < n; i++) begin
         line <= bits[i];
         repeat (bc) @(posedge mclk);
      end
      line <= 1'b1;
   endtask
   task automatic arm0(input logic [7:0] b);
      m0Byte = b;
      m0Arm = 1'b1;
   endtask
   task automatic disarm;
      m0Arm = 1'b0;
      line <= 1'b1;
   endtask
   // New bit on each falling shift clock, LSB first
   always @(negedge shiftClk) begin
      if (m0Arm) begin
         line <= m0Byte[0];
         m0Byte <= {1'b1, m0Byte[7:1]};
      end
   end
endmodule

// File: verif/sp4_serial_port_tb_top.sv
`timescale 1ns/1ps
`include "sp4_map.vh"
module sp4_serial_port_tb_top;
   reg mclk, reset_n, wbCyc, wbStb, wbWe;
   reg [3:0] wbAdr;
   reg [7:0] wbDat;
   reg [1:0] tmrCnt = 2'h0;
   wire [31:0] wbDatO;
   wire wbAck, rxLine, dOut, dOe, sClk;
   int n_errors, compares;
   logic [31:0] rd;
   logic [10:0] got;
   time t0;
   sp4_serial_port u_dut (.mclk(mclk), .reset_n(reset_n),
      .wb_cyc_i(wbCyc), .wb_stb_i(wbStb), .wb_we_i(wbWe),
      .wb_adr_i(wbAdr), .wb_sel_i(4'h1), .wb_dat_i({24'h0, wbDat}),
      .wb_dat_o(wbDatO), .wb_ack_o(wbAck),
      .timerOverflow(tmrCnt[1]), .serialDataIn(rxLine),
      .serialDataOut(dOut), .serialDataOe(dOe), .shiftClockOut(sClk));
   sp4_line_model u_line (.mclk(mclk), .shiftClk(sClk), .line(rxLine));
   initial begin
      mclk = 1'b0;
      forever #20 mclk = ~mclk;
   end
   // Overflow every 4 clocks keeps mode 1 and 3 frames short
   always @(posedge mclk) tmrCnt <= tmrCnt + 2'h1;
   // ------------------------------
   // Bus and check tasks
   // ------------------------------
   task automatic wb(input logic we, input logic [3:0] a,
         input logic [7:0] d);
      int t;
      t = 0;
      wbCyc <= 1'b1;
      wbStb <= 1'b1;
      wbWe <= we;
      wbAdr <= a;
      wbDat <= d;
      @(posedge mclk);
      while (wbAck !== 1'b1 && t < 20) begin
         @(posedge mclk);
         t++;
      end
      if (t == 20) n_errors++;
      rd = wbDatO;
      wbCyc <= 1'b0;
      wbStb <= 1'b0;
      wbWe <= 1'b0;
      @(posedge mclk);
   endtask
   task automatic chk(input string nm, input logic [31:0] e, s);
      compares++;
      if (s !== e) begin
         $display("wrong value %s expected %h seen %h", nm, e, s);
         n_errors++;
      end
   endtask
   task automatic rchk(input logic [3:0] a, input logic [31:0] m, e,
         input string nm);
      wb(1'b0, a, 8'h00);
      chk(nm, e, rd & m);
   endtask
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      wb(1'b1, a, d);
   endtask
   task automatic waitf(input logic [31:0] m);
      for (int i = 0; i < 200; i++) begin
         wb(1'b0, `SP4_ADDR_CTRL, 8'h00);
         if ((rd & m) !== 32'h0) break;
      end
   endtask
   task automatic txcap(input int n, input int bc);
      int t;
      got = 11'h0;
      t = 0;
      while (dOut !== 1'b0 && t < 3000) begin
         @(posedge mclk);
         t++;
      end
      repeat (bc / 2) @(posedge mclk);
      for (int i = 0; i < n; i++) begin
         got[i] = dOut;
         if (i < n - 1) repeat (bc) @(posedge mclk);
      end
   endtask
   task automatic final_report;
      $display("errors %0d compares %0d", n_errors, compares);
      if (n_errors == 0 && compares > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   initial begin
      repeat (30000) @(posedge mclk);
      n_errors++;
      final_report;
   end
   // ------------------------------
   // Tests
   // ------------------------------
   initial begin
      {wbCyc, wbStb, wbWe, wbAdr, wbDat} = 0;
      reset_n = 1'b0;
      n_errors = 0;
      compares = 0;
      repeat (3) @(posedge mclk);
      reset_n <= 1'b1;
      @(posedge mclk);
      rchk(`SP4_ADDR_CTRL, 32'hff, 32'h0, "ctrl reset");
      rchk(`SP4_ADDR_PWR, 32'hff, 32'h0, "pwr reset");
      rchk(4'h3, 32'hffffffff, 32'h0, "unmapped");
      $display("test reset done");
      wr(`SP4_ADDR_PWR, 8'h80);
      for (int m = 1; m < 4; m++) begin
         wr(`SP4_ADDR_CTRL, {m[1:0], 6'h08});
         wr(`SP4_ADDR_BUF, 8'h5a ^ m[7:0]);
         txcap(m == 1 ? 10 : 11, m == 2 ? 32 : 64);
         chk("tx frame", {m != 1, 1'b1, 8'h5a ^ m[7:0], 1'b0}, got);
         rchk(`SP4_ADDR_CTRL, 32'h2, 32'h2, "tx flag");
      end
      $display("test async transmit done");
      wr(`SP4_ADDR_CTRL, 8'h90);
      u_line.send(11'h0, 1, 4);
      repeat (40) @(posedge mclk);
      u_line.send({2'b11, 8'h3c, 1'b0}, 11, 32);
      rchk(`SP4_ADDR_CTRL, 32'h5, 32'h5, "rx flags");
      rchk(`SP4_ADDR_BUF, 32'hff, 32'h3c, "rx data");
      u_line.send({2'b10, 8'hc3, 1'b0}, 11, 32);
      rchk(`SP4_ADDR_BUF, 32'hff, 32'h3c, "rx held");
      $display("test async receive done");
      wr(`SP4_ADDR_CTRL, 8'h70);
      u_line.send({2'b00, 8'h81, 1'b0}, 10, 64);
      rchk(`SP4_ADDR_CTRL, 32'h81, 32'h0, "filtered");
      wr(`SP4_ADDR_PWR, 8'hc0);
      rchk(`SP4_ADDR_CTRL, 32'h80, 32'h80, "frame error");
      u_line.send({2'b01, 8'h42, 1'b0}, 10, 64);
      rchk(`SP4_ADDR_CTRL, 32'h85, 32'h85, "error sticky");
      rchk(`SP4_ADDR_BUF, 32'hff, 32'h42, "mode1 data");
      wr(`SP4_ADDR_CTRL, 8'h70);
      rchk(`SP4_ADDR_CTRL, 32'h80, 32'h0, "error cleared");
      wr(`SP4_ADDR_PWR, 8'h80);
      rchk(`SP4_ADDR_CTRL, 32'hc0, 32'h40, "mode bits");
      $display("test framing done");
      for (int f = 0; f < 2; f++) begin
         wr(`SP4_ADDR_CTRL, f ? 8'h20 : 8'h00);
         wr(`SP4_ADDR_BUF, 8'h96);
         for (int i = 0; i < 8; i++) begin
            @(negedge sClk);
            got[i] = dOut;
            if (i == 0) t0 = $time;
            if (i == 1) chk("shift period", f ? 160 : 480, 32'($time - t0));
         end
         repeat (12) @(posedge mclk);
         chk("m0 tx", 32'h96, {24'h0, got[7:0]});
         rchk(`SP4_ADDR_CTRL, 32'h2, 32'h2, "m0 tx flag");
      end
      $display("test shift transmit done");
      u_line.arm0(8'ha7);
      wr(`SP4_ADDR_CTRL, 8'h30);
      waitf(32'h1);
      rchk(`SP4_ADDR_BUF, 32'hff, 32'ha7, "m0 rx");
      u_line.arm0(8'h11);
      repeat (100) @(posedge mclk);
      rchk(`SP4_ADDR_BUF, 32'hff, 32'ha7, "m0 rx stop");
      u_line.disarm;
      $display("test shift receive done");
      final_report;
   end
endmodule
